// ===== logic/rt_mode_command_options.sv
// mode command option logic: time-tag clear, self-test word choice, bus shutdown
`timescale 1ns/10ps
module rt_mode_command_options #(
	parameter int TICK_DIV = rt_opt_pkg::TICK_CYCLES
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_master_reset_pin,
	input wire logic i_soft_reset_bit,
	input wire logic i_timetag_clear_bit,
	input wire logic i_alt_selftest_word_select,
	input wire logic i_host_shutdown_handling,
	input wire logic i_shutdown_scope_select,
	input wire logic i_bus_a_tx_inhibit,
	input wire logic i_bus_b_tx_inhibit,
	input wire logic i_active_bus_b,
	input wire logic [15:0] i_bus_a_select,
	input wire logic [15:0] i_bus_b_select,
	input wire logic i_mc_valid,
	input wire logic [4:0] i_mc_code,
	input wire logic [15:0] i_mc_data,
	input wire logic [rt_opt_pkg::STATUS_LOW_W-1:0] i_selftest_status,
	input wire logic i_host_wr,
	input wire logic i_host_rd,
	input wire logic [15:0] i_host_addr,
	input wire logic [15:0] i_host_wdata,
	output logic [15:0] o_host_rdata,
	output logic [15:0] o_bit_word,
	output logic o_bit_word_valid,
	output logic o_tx_enable_a,
	output logic o_tx_enable_b,
	output logic o_rx_enable_a,
	output logic o_rx_enable_b,
	output logic [15:0] o_timetag
);
	import rt_opt_pkg::*;

	typedef struct packed {
		logic [1:0] tx_sd;
		logic [1:0] rx_sd;
		logic [15:0] alt_word;
		logic [15:0] rdata;
		logic [15:0] bit_word;
		logic bit_valid;
	} opt_state_t;

	opt_state_t st_r;
	opt_state_t st_nxt;
	logic inact;
	logic [15:0] inact_select;
	logic auto_ok;
	logic do_shutdown;
	logic do_override;
	logic reactivate_all;
	logic [15:0] default_word;
	logic sync_cmd;

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	// inactive bus is the one not carrying this command
	assign inact = ~i_active_bus_b;
	assign inact_select = inact ? i_bus_b_select : i_bus_a_select;
	// selected variants act only when the device owns shutdown duty
	assign auto_ok = ~i_host_shutdown_handling;
	assign do_shutdown = i_mc_valid && ((i_mc_code == MC_SHUTDOWN)
		|| (i_mc_code == MC_SEL_SHUTDOWN && auto_ok && i_mc_data == inact_select));
	assign do_override = i_mc_valid && ((i_mc_code == MC_OVERRIDE)
		|| (i_mc_code == MC_SEL_OVERRIDE && auto_ok && i_mc_data == inact_select));
	assign reactivate_all = i_master_reset_pin || i_soft_reset_bit
		|| (i_mc_valid && i_mc_code == MC_RESET_RT);
	assign sync_cmd = i_mc_valid && i_mc_code == MC_SYNC;

	// default word: shutdown flags on top, device status below
	assign default_word = {st_r.tx_sd[BUS_A], st_r.rx_sd[BUS_A], st_r.tx_sd[BUS_B],
		st_r.rx_sd[BUS_B], i_selftest_status};

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.bit_valid = 1'b0;
		// shutdown flags per bus
		if (reactivate_all) begin
			st_nxt.tx_sd = 2'b00;
			st_nxt.rx_sd = 2'b00;
		end else if (do_shutdown) begin
			st_nxt.tx_sd[inact] = 1'b1;
			if (i_shutdown_scope_select) begin
				st_nxt.rx_sd[inact] = 1'b1;
			end
		end else if (do_override) begin
			st_nxt.tx_sd[inact] = 1'b0;
			st_nxt.rx_sd[inact] = 1'b0;
		end
		// transmit BIT word answer
		if (i_mc_valid && i_mc_code == MC_TX_BIT_WORD) begin
			st_nxt.bit_valid = 1'b1;
			st_nxt.bit_word = i_alt_selftest_word_select ? st_r.alt_word
				: default_word;
		end
		// host register port; default word is read only
		if (i_host_wr && i_host_addr == ADDR_SELFTEST_ALTERNATE) begin
			st_nxt.alt_word = i_host_wdata;
		end
		if (i_host_rd) begin
			case (i_host_addr)
				ADDR_SELFTEST_DEFAULT: begin
					st_nxt.rdata = default_word;
				end
				ADDR_SELFTEST_ALTERNATE: begin
					st_nxt.rdata = st_r.alt_word;
				end
				default: begin
					st_nxt.rdata = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			st_r <= '{tx_sd: 2'b00, rx_sd: 2'b00, alt_word: ALT_WORD_RESET,
				rdata: 16'h0000, bit_word: 16'h0000, bit_valid: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// host inhibits always gate transmit, which is how host-handled shutdown works
	assign o_tx_enable_a = ~st_r.tx_sd[BUS_A] & ~i_bus_a_tx_inhibit;
	assign o_tx_enable_b = ~st_r.tx_sd[BUS_B] & ~i_bus_b_tx_inhibit;
	assign o_rx_enable_a = ~st_r.rx_sd[BUS_A];
	assign o_rx_enable_b = ~st_r.rx_sd[BUS_B];
	assign o_host_rdata = st_r.rdata;
	assign o_bit_word = st_r.bit_word;
	assign o_bit_word_valid = st_r.bit_valid;

	timetag_counter #(
		.DIV(TICK_DIV),
		.WIDTH(16)
	) u_timetag (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_hold_clear(i_timetag_clear_bit),
		.i_sync_clear(sync_cmd),
		.o_count(o_timetag)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);

	// accepted commands, after the priority between events has been applied
	sequence s_shut_cmd;
		do_shutdown && !reactivate_all;
	endsequence
	sequence s_over_cmd;
		do_override && !reactivate_all && !do_shutdown;
	endsequence

	// self-test word answers follow the select bit
	a_bit_default: assert property (i_mc_valid && i_mc_code == MC_TX_BIT_WORD
		&& !i_alt_selftest_word_select |=> o_bit_word == $past(default_word) && o_bit_word_valid)
		else $error("default self-test word not returned");
	a_bit_alt: assert property (i_mc_valid && i_mc_code == MC_TX_BIT_WORD
		&& i_alt_selftest_word_select |=> o_bit_word == $past(st_r.alt_word))
		else $error("alternate self-test word not returned");
	// the bus that was inactive at the command stays blocked, even if activity moves
	a_shut_blocks: assert property (s_shut_cmd ##1 !reactivate_all && !do_override [*2]
		|-> !($past(inact, 2) ? o_tx_enable_b : o_tx_enable_a))
		else $error("inactive transmitter still enabled after shutdown");
	a_shut_status: assert property (s_shut_cmd |=>
		($past(inact) ? default_word[BIT_B_TX_SD] : default_word[BIT_A_TX_SD]))
		else $error("shutdown not reflected in self-test bits");
	a_scope_rx: assert property (s_shut_cmd ##0 !i_shutdown_scope_select
		&& !st_r.rx_sd[inact] |=> !st_r.rx_sd[$past(inact)])
		else $error("receiver disabled in transmitter-only scope");
	a_override_on: assert property (s_over_cmd |=>
		!st_r.tx_sd[$past(inact)] && !st_r.rx_sd[$past(inact)])
		else $error("override did not re-enable inactive bus");
	// reactivation and refusal cases
	a_reactivate: assert property (reactivate_all |=> st_r.tx_sd == 2'b00
		&& o_rx_enable_a && o_rx_enable_b)
		else $error("reactivation event left a bus shut down");
	a_host_ignores: assert property (i_mc_valid && i_mc_code == MC_SEL_SHUTDOWN
		&& i_host_shutdown_handling && !reactivate_all |=> $stable(st_r.tx_sd))
		else $error("selected shutdown acted while host handles it");
	a_sel_mismatch: assert property (i_mc_valid && i_mc_code == MC_SEL_SHUTDOWN
		&& i_mc_data != inact_select && !reactivate_all |=> $stable(st_r.tx_sd))
		else $error("selected shutdown acted on mismatched data");
	a_mc4_always: assert property (i_mc_valid && i_mc_code == MC_SHUTDOWN
		&& i_host_shutdown_handling && !reactivate_all |=> st_r.tx_sd[$past(inact)])
		else $error("unconditional shutdown ignored under host handling");
	// device status must reach the host through the read port
	a_status_low: assert property (i_host_rd && i_host_addr == ADDR_SELFTEST_DEFAULT |=>
		o_host_rdata[STATUS_LOW_W-1:0] == $past(i_selftest_status))
		else $error("device status missing from default word");
endmodule : rt_mode_command_options

// ===== logic/rt_opt_pkg.sv
// constants shared by the mode command option logic
package rt_opt_pkg;
	// register addresses
	localparam logic [15:0] ADDR_SELFTEST_DEFAULT = 16'h0014;
	localparam logic [15:0] ADDR_SELFTEST_ALTERNATE = 16'h0015;
	localparam logic [15:0] ALT_WORD_RESET = 16'h0000;
	// mode codes
	localparam logic [4:0] MC_SYNC = 5'h01;
	localparam logic [4:0] MC_SHUTDOWN = 5'h04;
	localparam logic [4:0] MC_OVERRIDE = 5'h05;
	localparam logic [4:0] MC_RESET_RT = 5'h08;
	localparam logic [4:0] MC_TX_BIT_WORD = 5'h13;
	localparam logic [4:0] MC_SEL_SHUTDOWN = 5'h14;
	localparam logic [4:0] MC_SEL_OVERRIDE = 5'h15;
	// shutdown status field in the default self-test word
	localparam int BIT_A_TX_SD = 15;
	localparam int BIT_A_RX_SD = 14;
	localparam int BIT_B_TX_SD = 13;
	localparam int BIT_B_RX_SD = 12;
	localparam int STATUS_LOW_W = 12;
	// bus indices
	localparam int BUS_A = 0;
	localparam int BUS_B = 1;
	// time-tag tick
	localparam int CLK_PERIOD_NS = 5;
	localparam int TICK_PERIOD_NS = 1000;
	localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [15:0] TIMETAG_RESET = 16'h0000;
endpackage : rt_opt_pkg

// ===== logic/timetag_counter.sv
// time-tag counter with clock divider, hold-clear and sync reset
`timescale 1ns/10ps
module timetag_counter #(
	parameter int DIV = rt_opt_pkg::TICK_CYCLES,
	parameter int WIDTH = 16
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_hold_clear,
	input wire logic i_sync_clear,
	output logic [WIDTH-1:0] o_count
);
	import rt_opt_pkg::*;

	typedef struct packed {
		logic [15:0] div;
		logic [WIDTH-1:0] cnt;
	} tt_state_t;

	tt_state_t st_r;
	tt_state_t st_nxt;
	logic tick;

	// ----------------------------------------
	// divider and counter
	// ----------------------------------------
	// divider clears along with the count on hold or sync, so the phase restarts on release
	always_comb begin
		st_nxt = st_r;
		tick = (st_r.div == 16'(DIV - 1));
		if (i_hold_clear || i_sync_clear) begin
			st_nxt.cnt = '0;
			st_nxt.div = '0;
		end else if (tick) begin
			st_nxt.div = '0;
			st_nxt.cnt = st_r.cnt + WIDTH'(1);
		end else begin
			st_nxt.div = st_r.div + 16'h0001;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_count = st_r.cnt;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);

	a_hold_zero: assert property (i_hold_clear |=> o_count == '0)
		else $error("time-tag not held at zero");
	a_sync_zero: assert property (i_sync_clear |=> o_count == '0)
		else $error("time-tag not cleared by sync");
	a_held_still: assert property (i_hold_clear ##1 i_hold_clear |=> $stable(o_count))
		else $error("time-tag counted while held");
endmodule : timetag_counter

// ===== sim/bc_model.sv
// bus controller model that issues mode commands to the terminal
`timescale 1ns/10ps
module bc_model (
	input wire logic i_core_clk,
	output logic o_mc_valid,
	output logic [4:0] o_mc_code,
	output logic [15:0] o_mc_data
);
	// idle at time zero
	initial begin
		o_mc_valid = 1'b0;
		o_mc_code = 5'h00;
		o_mc_data = 16'h0000;
	end
	// one command per call, held for exactly one sampling edge
	task automatic send(input logic [4:0] code, input logic [15:0] data);
		@(negedge i_core_clk);
		o_mc_valid = 1'b1;
		o_mc_code = code;
		o_mc_data = data;
		@(negedge i_core_clk);
		o_mc_valid = 1'b0;
		// invert the idle fields so the terminal cannot lean on stale values
		o_mc_code = ~code;
		o_mc_data = ~data;
	endtask : send
endmodule : bc_model

// ===== sim/rt_mode_command_options_tb.sv
// self-checking bench for the mode command option logic
`timescale 1ns/10ps
`define CHK(nm, ex, ac) begin checks_done++; if ((ac) !== (ex)) begin error_cnt++; \
	$display("Error %s exp %h got %h", nm, ex, ac); end end
module rt_mode_command_options_tb;
	import rt_opt_pkg::*;
	typedef struct packed {logic [4:0] code; logic [15:0] data; logic actb; logic scope;
		logic host; logic [3:0] sd;} row_t;
	localparam logic [11:0] STAT = 12'h5A5;
	localparam int TB_DIV = 4;
	logic clk = 1'b0, rstn = 1'b0, mr = 1'b0, soft_reset_bit = 1'b0, ttclr = 1'b0, alt = 1'b0;
	logic host = 1'b0, scope = 1'b0, inh_a = 1'b0, inh_b = 1'b0, actb = 1'b0;
	logic wr = 1'b0, rd = 1'b0;
	logic [15:0] addr = 16'h0000, wdata = 16'h0000, got;
	logic mc_valid, bw_valid, tx_a, tx_b, rx_a, rx_b;
	logic [4:0] mc_code;
	logic [15:0] mc_data, rdata, bit_word, timetag;
	int error_cnt = 0, checks_done = 0;
	row_t rows [14];
	bc_model BC (.i_core_clk(clk), .o_mc_valid(mc_valid), .o_mc_code(mc_code),
		.o_mc_data(mc_data));
	rt_mode_command_options #(.TICK_DIV(TB_DIV)) DUT (.i_core_clk(clk), .i_rstn(rstn),
		.i_master_reset_pin(mr), .i_soft_reset_bit(soft_reset_bit), .i_timetag_clear_bit(ttclr),
		.i_alt_selftest_word_select(alt), .i_host_shutdown_handling(host),
		.i_shutdown_scope_select(scope), .i_bus_a_tx_inhibit(inh_a),
		.i_bus_b_tx_inhibit(inh_b), .i_active_bus_b(actb), .i_bus_a_select(16'h00A1),
		.i_bus_b_select(16'h00B2), .i_mc_valid(mc_valid), .i_mc_code(mc_code),
		.i_mc_data(mc_data), .i_selftest_status(STAT), .i_host_wr(wr), .i_host_rd(rd),
		.i_host_addr(addr), .i_host_wdata(wdata), .o_host_rdata(rdata),
		.o_bit_word(bit_word), .o_bit_word_valid(bw_valid), .o_tx_enable_a(tx_a),
		.o_tx_enable_b(tx_b), .o_rx_enable_a(rx_a), .o_rx_enable_b(rx_b),
		.o_timetag(timetag));
	// 200 MHz core clock
	initial begin
		forever #2.5 clk = ~clk;
	end
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : summarize
	// enables follow the flags, then the answered word must mirror them
	task automatic chk_sd(input logic [3:0] sd);
		`CHK("enables", ~sd, {tx_a, rx_a, tx_b, rx_b})
		BC.send(MC_TX_BIT_WORD, 16'h0000);
		`CHK("bit word", {1'b1, sd, STAT}, {bw_valid, bit_word})
	endtask : chk_sd
	// read data lands one cycle after the strobe
	task automatic reg_rd(input logic [15:0] a);
		@(negedge clk);
		rd = 1'b1;
		addr = a;
		@(negedge clk);
		rd = 1'b0;
		got = rdata;
	endtask : reg_rd
	task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr = 1'b0;
	endtask : reg_wr
	// generous cap, the sequence needs under 150 cycles
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		summarize();
	end
	// ---------------------------------------------------------------
	// stimulus
	// ---------------------------------------------------------------
	initial begin
		rows = '{
			'{MC_SHUTDOWN, 16'h0000, 1'b0, 1'b1, 1'b0, 4'h3},
			'{MC_OVERRIDE, 16'h0000, 1'b0, 1'b1, 1'b0, 4'h0},
			'{MC_SHUTDOWN, 16'h0000, 1'b0, 1'b0, 1'b0, 4'h2},
			'{MC_RESET_RT, 16'h0000, 1'b0, 1'b0, 1'b0, 4'h0},
			'{MC_SHUTDOWN, 16'h0000, 1'b1, 1'b1, 1'b1, 4'hC},
			'{MC_OVERRIDE, 16'h0000, 1'b1, 1'b1, 1'b1, 4'h0},
			'{MC_SEL_SHUTDOWN, 16'h00B2, 1'b0, 1'b1, 1'b1, 4'h0},
			'{MC_SEL_SHUTDOWN, 16'h00B2, 1'b0, 1'b1, 1'b0, 4'h3},
			'{MC_SEL_OVERRIDE, 16'h00A1, 1'b0, 1'b1, 1'b0, 4'h3},
			'{MC_SEL_OVERRIDE, 16'h00B2, 1'b0, 1'b1, 1'b1, 4'h3},
			'{MC_SEL_OVERRIDE, 16'h00B2, 1'b0, 1'b1, 1'b0, 4'h0},
			'{MC_SEL_SHUTDOWN, 16'h00B2, 1'b1, 1'b1, 1'b0, 4'h0},
			'{MC_SEL_SHUTDOWN, 16'h00A1, 1'b1, 1'b0, 1'b0, 4'h8},
			'{MC_SYNC, 16'h0000, 1'b1, 1'b0, 1'b0, 4'h8}};
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		`CHK("reset outputs", 33'h0, {rdata, bw_valid, bit_word})
		reg_rd(ADDR_SELFTEST_DEFAULT);
		`CHK("default word", {4'h0, STAT}, got)
		chk_sd(4'h0);
		foreach (rows[i]) begin
			@(negedge clk);
			actb = rows[i].actb;
			scope = rows[i].scope;
			host = rows[i].host;
			BC.send(rows[i].code, rows[i].data);
			chk_sd(rows[i].sd);
		end
		// master reset pin, then soft reset, each reopen a shut bus
		mr = 1'b1;
		@(negedge clk);
		mr = 1'b0;
		chk_sd(4'h0);
		actb = 1'b0;
		scope = 1'b1;
		BC.send(MC_SHUTDOWN, 16'h0000);
		chk_sd(4'h3);
		soft_reset_bit = 1'b1;
		@(negedge clk);
		soft_reset_bit = 1'b0;
		chk_sd(4'h0);
		inh_a = 1'b1;
		@(negedge clk);
		`CHK("tx inhibit", 2'b01, {tx_a, tx_b})
		inh_a = 1'b0;
		// default word is read-only, alternate word fully user-owned
		reg_wr(ADDR_SELFTEST_DEFAULT, 16'hFFFF);
		reg_rd(ADDR_SELFTEST_DEFAULT);
		`CHK("default kept", {4'h0, STAT}, got)
		reg_wr(ADDR_SELFTEST_ALTERNATE, 16'h3C96);
		reg_rd(ADDR_SELFTEST_ALTERNATE);
		`CHK("alt word", 16'h3C96, got)
		reg_rd(16'h0016);
		`CHK("unmapped", 16'h0000, got)
		alt = 1'b1;
		BC.send(MC_TX_BIT_WORD, 16'h0000);
		`CHK("alt answer", {1'b1, 16'h3C96}, {bw_valid, bit_word})
		@(negedge clk);
		`CHK("valid pulse", 1'b0, bw_valid)
		alt = 1'b0;
		// time-tag held by the clear bit, restarted by sync
		ttclr = 1'b1;
		repeat (12) @(negedge clk);
		`CHK("timetag held", 16'h0000, timetag)
		ttclr = 1'b0;
		repeat (12) @(negedge clk);
		`CHK("timetag runs", 16'(12 / TB_DIV), timetag)
		BC.send(MC_SYNC, 16'h0000);
		`CHK("timetag sync", 16'h0000, timetag)
		// mid-run reset drops the flags, the alternate word and the count
		BC.send(MC_SHUTDOWN, 16'h0000);
		`CHK("pre-reset", 2'b00, {tx_b, rx_b})
		rstn = 1'b0;
		@(negedge clk);
		rstn = 1'b1;
		`CHK("reset count", 16'h0000, timetag)
		chk_sd(4'h0);
		reg_rd(ADDR_SELFTEST_ALTERNATE);
		`CHK("reset alt", ALT_WORD_RESET, got)
		summarize();
	end
endmodule : rt_mode_command_options_tb
